// ==== ser_pkg.sv ====
// Constants for the status event register sets
package ser_pkg;

    // ------------------------------------------------------------------
    // Register widths and reset values
    // ------------------------------------------------------------------
    localparam int        REG_W        = 8;
    localparam logic [7:0] EVENT_RST   = 8'h00;
    localparam logic [7:0] ENABLE_RST  = 8'h00;

    // ------------------------------------------------------------------
    // Register selects on the query/command port
    // ------------------------------------------------------------------
    localparam logic [2:0] SEL_STD_EVENT   = 3'h0;
    localparam logic [2:0] SEL_STD_ENABLE  = 3'h1;
    localparam logic [2:0] SEL_OP_EVENT    = 3'h2;
    localparam logic [2:0] SEL_OP_ENABLE   = 3'h3;
    localparam logic [2:0] SEL_OP_COND     = 3'h4;
    localparam logic [2:0] SEL_STATUS_BYTE = 3'h5;
    localparam logic [2:0] SEL_SRQ_ENABLE  = 3'h6;

    // ------------------------------------------------------------------
    // Standard event bit positions
    // ------------------------------------------------------------------
    localparam int STD_POWERUP_BIT  = 7;
    localparam int STD_CMD_FAULT    = 5;
    localparam int STD_UNSUPPORTED  = 4;
    localparam int STD_REPLY_OVF    = 2;
    localparam int STD_OP_COMPLETE  = 0;

    // ------------------------------------------------------------------
    // Operation bit positions
    // ------------------------------------------------------------------
    localparam int OP_LINK_FAULT    = 7;
    localparam int OP_TRIM_FAULT    = 6;
    localparam int OP_TUNING_IDLE   = 5;
    localparam int OP_FRESH_SAMPLE  = 4;
    localparam int OP_OVERRANGE     = 1;
    localparam int OP_LIMIT_TRIP    = 0;

    // ------------------------------------------------------------------
    // Status byte bit positions
    // ------------------------------------------------------------------
    localparam int SB_OP_SUMMARY    = 7;
    localparam int SB_STD_SUMMARY   = 5;

endpackage : ser_pkg

// ==== ser_status_regs.sv ====
// Status event register sets with query and enable-write port
// What this block does
// [R1] Query returns binary weighted register value
// [R2] Only enable registers accept writes
// [R3] Controller writes masks as weighted sums
// [R4] Condition bits follow live state, unlatched
// [R5] Standard event query returns then clears
// [R6] Clear-status and power-on clear event registers
// [R7] Enable cleared by writing zero, power-on
// [R8] Summary bits clear with their event register
// [R9] Bit 7 standard: power-up seen
// [R10] Bit 5 standard: command fault
// [R11] Bit 4 standard: unsupported action
// [R12] Bit 2 standard: reply overflow
// [R13] Bit 0 standard: operation complete after request
// [R14] Standard enable written, read, selects summary
// [R15] Operation enable, event, condition commands
// [R16] Bit 7 operation: processor link fault
// [R17] Bit 6 operation: trim data fault
// [R18] Bit 5 operation: tuning idle
// [R19] Bit 4 operation: fresh sample
// [R20] Bit 1 operation: input overrange
// [R21] Bit 0 operation: limit trip with display
// [R22] Event bits latch until cleared
// [R23] Enabled event bits OR into summary
// [R24] Summaries in status byte bits 7, 5
`timescale 1ns/100ps
module ser_status_regs (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       clk_en_i,
    // Query and command port from the command parser
    input  wire logic       rd_i,
    input  wire logic       wr_i,
    input  wire logic [2:0] sel_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       clear_status_i,
    output logic      [7:0] rdata_o,
    output logic            rvalid_o,
    output logic            wr_refused_o,
    // Standard event sources: one-cycle pulses, plus the ops_pending_i level
    input  wire logic       command_fault_i,
    input  wire logic       unsupported_action_i,
    input  wire logic       reply_overflow_i,
    input  wire logic       op_complete_req_i,
    input  wire logic       ops_pending_i,
    // Operation condition sources, levels from pins
    input  wire logic       processor_link_fault_i,
    input  wire logic       trim_data_fault_i,
    input  wire logic       tuning_active_i,
    input  wire logic       fresh_sample_i,
    input  wire logic       input_overrange_i,
    input  wire logic       input_alarming_i,
    input  wire logic       alarm_display_on_i,
    // Summaries
    output logic            std_event_summary_bit_o,
    output logic            operation_summary_bit_o,
    output logic      [7:0] status_byte_o
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic ser_summary(input logic [7:0] ev, input logic [7:0] en);
        ser_summary = |(ev & en); // R23
    endfunction : ser_summary

    // Writable selects, used by the refusal flag; the write path compares sel_i itself
    function automatic logic ser_is_enable(input logic [2:0] sel);
        ser_is_enable = (sel == ser_pkg::SEL_STD_ENABLE) ||
                        (sel == ser_pkg::SEL_OP_ENABLE)  ||
                        (sel == ser_pkg::SEL_SRQ_ENABLE);
    endfunction : ser_is_enable

    // ------------------------------------------------------------------
    // Pin synchronisers for live condition sources
    // ------------------------------------------------------------------
    // Raw pins pass two flops before any gating, so no glitch from the
    // alarm qualifier or the idle inversion can reach the event latch
    localparam logic [6:0] PIN_RST = 7'h10;

    logic [6:0] pin_raw;
    logic [6:0] pin_meta;
    logic [6:0] pin_sync;
    logic [6:0] next_pin_meta;
    logic [6:0] next_pin_sync;

    assign pin_raw = {processor_link_fault_i,
                      trim_data_fault_i,
                      tuning_active_i,
                      fresh_sample_i,
                      input_overrange_i,
                      input_alarming_i,
                      alarm_display_on_i};

    always_comb begin
        next_pin_meta = pin_raw;
        next_pin_sync = pin_meta;
    end

    // Tuning starts as active so no false idle edge follows reset
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pin_meta <= PIN_RST;
            pin_sync <= PIN_RST;
        end else if (clk_en_i) begin
            pin_meta <= next_pin_meta;
            pin_sync <= next_pin_sync;
        end
    end

    // Condition register is purely live, nothing to clear
    logic [7:0] op_condition;
    always_comb begin
        op_condition = 8'h00;
        op_condition[ser_pkg::OP_LINK_FAULT]   = pin_sync[6];               // R16
        op_condition[ser_pkg::OP_TRIM_FAULT]   = pin_sync[5];               // R17
        op_condition[ser_pkg::OP_TUNING_IDLE]  = ~pin_sync[4];              // R18
        op_condition[ser_pkg::OP_FRESH_SAMPLE] = pin_sync[3];               // R19
        op_condition[ser_pkg::OP_OVERRANGE]    = pin_sync[2];               // R20
        op_condition[ser_pkg::OP_LIMIT_TRIP]   = pin_sync[1] & pin_sync[0]; // R21 R4
    end

    // ------------------------------------------------------------------
    // Event, enable and answer registers
    // ------------------------------------------------------------------
    logic       rd_take;
    logic       wr_take;
    logic [7:0] status_byte;

    assign rd_take = rd_i;
    // Query wins over write so only one access is answered per cycle
    assign wr_take = wr_i & ~rd_i;

    // ------------------------------------------------------------------
    // Condition edge history
    // ------------------------------------------------------------------
    logic [7:0] op_cond_prev;
    logic [7:0] next_op_cond_prev;

    always_comb begin
        next_op_cond_prev = op_condition;
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            op_cond_prev <= 8'h00;
        end else if (clk_en_i) begin
            op_cond_prev <= next_op_cond_prev;
        end
    end

    // ------------------------------------------------------------------
    // Pending standard event sources
    // ------------------------------------------------------------------
    logic opc_armed;
    logic powerup_pending;
    logic next_opc_armed;
    logic next_powerup_pending;

    always_comb begin
        // Armed request waits out every pending operation
        next_opc_armed       = (opc_armed | op_complete_req_i) & ops_pending_i; // R13
        next_powerup_pending = 1'b0;
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            opc_armed       <= 1'b0;
            powerup_pending <= 1'b1; // R9
        end else if (clk_en_i) begin
            opc_armed       <= next_opc_armed;
            powerup_pending <= next_powerup_pending;
        end
    end

    // ------------------------------------------------------------------
    // Event latches
    // ------------------------------------------------------------------
    logic [7:0] standard_event_latch;
    logic [7:0] operation_event_latch;
    logic [7:0] next_standard_event_latch;
    logic [7:0] next_operation_event_latch;
    logic [7:0] std_set;
    logic [7:0] op_set;

    always_comb begin
        std_set = 8'h00;
        std_set[ser_pkg::STD_POWERUP_BIT] = powerup_pending;      // R9
        std_set[ser_pkg::STD_CMD_FAULT]   = command_fault_i;      // R10
        std_set[ser_pkg::STD_UNSUPPORTED] = unsupported_action_i; // R11
        std_set[ser_pkg::STD_REPLY_OVF]   = reply_overflow_i;     // R12
        std_set[ser_pkg::STD_OP_COMPLETE] = (opc_armed | op_complete_req_i)
                                            & ~ops_pending_i;     // R13
        // Rising condition edges latch as operation events
        op_set = op_condition & ~op_cond_prev;

        next_standard_event_latch  = standard_event_latch;
        next_operation_event_latch = operation_event_latch;
        if (clear_status_i) begin
            next_standard_event_latch  = 8'h00; // R6 R8
            next_operation_event_latch = 8'h00; // R6 R8
        end
        if (rd_take && (sel_i == ser_pkg::SEL_STD_EVENT)) begin
            next_standard_event_latch = 8'h00; // R5
        end
        if (rd_take && (sel_i == ser_pkg::SEL_OP_EVENT)) begin
            next_operation_event_latch = 8'h00; // R15
        end
        // Set wins so no event is lost in a clear cycle
        next_standard_event_latch  = next_standard_event_latch | std_set; // R22
        next_operation_event_latch = next_operation_event_latch | op_set; // R22
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            standard_event_latch  <= ser_pkg::EVENT_RST; // R6
            operation_event_latch <= ser_pkg::EVENT_RST; // R6
        end else if (clk_en_i) begin
            standard_event_latch  <= next_standard_event_latch;
            operation_event_latch <= next_operation_event_latch;
        end
    end

    // ------------------------------------------------------------------
    // Enable masks
    // ------------------------------------------------------------------
    logic [7:0] std_enable;
    logic [7:0] op_enable;
    logic [7:0] srq_enable;
    logic [7:0] next_std_enable;
    logic [7:0] next_op_enable;
    logic [7:0] next_srq_enable;

    always_comb begin
        next_std_enable = std_enable;
        next_op_enable  = op_enable;
        next_srq_enable = srq_enable;
        if (wr_take && (sel_i == ser_pkg::SEL_STD_ENABLE)) begin
            next_std_enable = wdata_i; // R2 R3 R7 R14
        end
        if (wr_take && (sel_i == ser_pkg::SEL_OP_ENABLE)) begin
            next_op_enable = wdata_i; // R2 R3 R7 R15
        end
        if (wr_take && (sel_i == ser_pkg::SEL_SRQ_ENABLE)) begin
            next_srq_enable = wdata_i; // R2 R7
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            std_enable <= ser_pkg::ENABLE_RST; // R7
            op_enable  <= ser_pkg::ENABLE_RST; // R7
            srq_enable <= ser_pkg::ENABLE_RST; // R7
        end else if (clk_en_i) begin
            std_enable <= next_std_enable;
            op_enable  <= next_op_enable;
            srq_enable <= next_srq_enable;
        end
    end

    // ------------------------------------------------------------------
    // Status byte, not latched: follows the event registers
    // ------------------------------------------------------------------
    always_comb begin
        status_byte = 8'h00;
        status_byte[ser_pkg::SB_OP_SUMMARY]  = ser_summary(operation_event_latch,
                                                           op_enable); // R24 R8
        status_byte[ser_pkg::SB_STD_SUMMARY] = ser_summary(standard_event_latch,
                                                           std_enable); // R24 R14
    end

    // ------------------------------------------------------------------
    // Query answers
    // ------------------------------------------------------------------
    logic [7:0] next_rdata;
    logic       next_rvalid;
    logic       next_refused;

    always_comb begin
        next_rdata   = rdata_o;
        next_rvalid  = rd_take;
        next_refused = wr_take & ~ser_is_enable(sel_i); // R2
        if (rd_take) begin
            unique case (sel_i)
                ser_pkg::SEL_STD_EVENT:   next_rdata = standard_event_latch;  // R1 R5
                ser_pkg::SEL_STD_ENABLE:  next_rdata = std_enable;            // R14
                ser_pkg::SEL_OP_EVENT:    next_rdata = operation_event_latch; // R15
                ser_pkg::SEL_OP_ENABLE:   next_rdata = op_enable;             // R15
                ser_pkg::SEL_OP_COND:     next_rdata = op_condition;          // R15 R4
                ser_pkg::SEL_STATUS_BYTE: next_rdata = status_byte;
                ser_pkg::SEL_SRQ_ENABLE:  next_rdata = srq_enable;
                default:                  next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rdata_o      <= 8'h00;
            rvalid_o     <= 1'b0;
            wr_refused_o <= 1'b0;
        end else if (clk_en_i) begin
            rdata_o      <= next_rdata;
            rvalid_o     <= next_rvalid;
            wr_refused_o <= next_refused;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign std_event_summary_bit_o = status_byte[ser_pkg::SB_STD_SUMMARY];
    assign operation_summary_bit_o = status_byte[ser_pkg::SB_OP_SUMMARY];
    assign status_byte_o           = status_byte;

endmodule : ser_status_regs

// ==== ser_status_regs_asserts.sv ====
// Concurrent checks on the query port and status byte
`timescale 1ns/100ps
module ser_status_regs_asserts (
    input wire logic       clk_i,
    input wire logic       rst_n_i,
    input wire logic       clk_en_i,
    input wire logic       rd_i,
    input wire logic       wr_i,
    input wire logic [2:0] sel_i,
    input wire logic [7:0] rdata_o,
    input wire logic       rvalid_o,
    input wire logic       wr_refused_o,
    input wire logic       std_event_summary_bit_o,
    input wire logic       operation_summary_bit_o,
    input wire logic [7:0] status_byte_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // ----------------------------------------------------------------
    // Handshake and summary checks
    // ----------------------------------------------------------------
    sequence s_query; clk_en_i && rd_i; endsequence
    sequence s_write; clk_en_i && wr_i && !rd_i; endsequence
    sequence s_enable_sel; sel_i inside {3'h1, 3'h3, 3'h6}; endsequence
    property p_answer; s_query |=> rvalid_o; endproperty
    a_answer: assert property (p_answer) else $error("query not answered");
    property p_quiet; clk_en_i && !rd_i |=> !rvalid_o; endproperty
    a_quiet: assert property (p_quiet) else $error("answer without query");
    property p_hold; !rvalid_o |-> $stable(rdata_o); endproperty
    a_hold: assert property (p_hold) else $error("answer moved between queries");
    property p_unmapped; s_query ##0 sel_i == 3'h7 |=> rdata_o == 8'h00; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_refuse; s_write ##0 !(sel_i inside {3'h1, 3'h3, 3'h6}) |=> wr_refused_o; endproperty
    a_refuse: assert property (p_refuse) else $error("read-only write not refused");
    property p_accept; s_write ##0 s_enable_sel |=> !wr_refused_o; endproperty
    a_accept: assert property (p_accept) else $error("enable write refused");
    property p_sb_op; status_byte_o[7] == operation_summary_bit_o; endproperty
    a_sb_op: assert property (p_sb_op) else $error("op summary misplaced");
    property p_sb_std; status_byte_o[5] == std_event_summary_bit_o; endproperty
    a_sb_std: assert property (p_sb_std) else $error("std summary misplaced");
    property p_sb_rest; (status_byte_o & 8'h5f) == 8'h00; endproperty
    a_sb_rest: assert property (p_sb_rest) else $error("unused status bits set");
endmodule : ser_status_regs_asserts

// ==== ser_ctrl_model.sv ====
// Controller model issuing status queries, enable writes and clears
`timescale 1ns/100ps
module ser_ctrl_model (
    input  wire logic       clk_i,
    input  wire logic [7:0] rdata_i,
    input  wire logic       rvalid_i,
    input  wire logic       refused_i,
    output logic            rd_o = 1'b0,
    output logic            wr_o = 1'b0,
    output logic      [2:0] sel_o = 3'h0,
    output logic      [7:0] wdata_o = 8'h00,
    output logic            clr_o = 1'b0
);
    // ----------------------------------------------------------------
    // Accesses; released lines show the inverse, never the old value
    // ----------------------------------------------------------------
    task ask(input logic [2:0] s, output logic [7:0] v);
        @(negedge clk_i);
        rd_o = 1'b1;
        sel_o = s;
        @(negedge clk_i);
        rd_o = 1'b0;
        sel_o = ~s;
        v = rvalid_i ? rdata_i : 8'hxx;
    endtask : ask
    task put(input logic [2:0] s, input logic [7:0] d, output logic r);
        @(negedge clk_i);
        wr_o = 1'b1;
        sel_o = s;
        wdata_o = d;
        @(negedge clk_i);
        wr_o = 1'b0;
        sel_o = ~s;
        wdata_o = ~d;
        r = refused_i;
    endtask : put
    task clr;
        @(negedge clk_i);
        clr_o = 1'b1;
        @(negedge clk_i);
        clr_o = 1'b0;
    endtask : clr
endmodule : ser_ctrl_model

// ==== status_event_register_sets_bench.sv ====
// Self-checking bench for the status event register sets
`timescale 1ns/100ps
module status_event_register_sets_bench;
    logic       clk_i = 1'b0;
    logic       rst_n_i = 1'b0;
    logic       rd, wr, clr, rv, refused, sb_std, sb_op, r;
    logic       opc_req = 1'b0, pend = 1'b0, disp = 1'b1, en = 1'b1;
    logic [2:0] sel;
    logic [2:0] ev = 3'h0;
    logic [7:0] wd, rdata, sbyte, v;
    logic [7:0] cond = 8'h00;
    int         n_fail = 0, n_compared = 0, cyc = 0;
    ser_status_regs u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .clk_en_i(en), .rd_i(rd),
        .wr_i(wr), .sel_i(sel), .wdata_i(wd), .clear_status_i(clr), .rdata_o(rdata),
        .rvalid_o(rv), .wr_refused_o(refused), .command_fault_i(ev[2]),
        .unsupported_action_i(ev[1]), .reply_overflow_i(ev[0]), .op_complete_req_i(opc_req),
        .ops_pending_i(pend), .processor_link_fault_i(cond[7]), .trim_data_fault_i(cond[6]),
        .tuning_active_i(!cond[5]), .fresh_sample_i(cond[4]), .input_overrange_i(cond[1]),
        .input_alarming_i(cond[0]), .alarm_display_on_i(disp),
        .std_event_summary_bit_o(sb_std), .operation_summary_bit_o(sb_op), .status_byte_o(sbyte));
    ser_ctrl_model u_m (.clk_i(clk_i), .rdata_i(rdata), .rvalid_i(rv), .refused_i(refused),
        .rd_o(rd), .wr_o(wr), .sel_o(sel), .wdata_o(wd), .clr_o(clr));
    // ----------------------------------------------------------------
    // Helpers and scenarios
    // ----------------------------------------------------------------
    task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task tk(input int n);
        repeat (n) @(negedge clk_i);
    endtask : tk
    task pulse(input logic [2:0] e);
        tk(1);
        ev = e;
        tk(1);
        ev = 3'h0;
    endtask : pulse
    task summarize;
        if (n_fail == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : summarize
    task t_power;
        u_m.ask(3'h0, v); chk("std event", 8'h80, v);
        u_m.ask(3'h0, v); chk("std event reread", 8'h00, v);
        for (int s = 1; s < 7; s++) begin
            u_m.ask(s[2:0], v); chk("power-on value", 8'h00, v);
        end
    endtask : t_power
    task t_std;
        pulse(3'h7);
        pulse(3'h4);
        u_m.ask(3'h0, v); chk("std events", 8'h34, v);
        u_m.ask(3'h0, v); chk("std cleared", 8'h00, v);
        pend = 1'b1;
        tk(1);
        opc_req = 1'b1;
        tk(1);
        opc_req = 1'b0;
        u_m.ask(3'h0, v); chk("opc pending", 8'h00, v);
        pend = 1'b0;
        tk(2);
        u_m.ask(3'h0, v); chk("opc done", 8'h01, v);
    endtask : t_std
    task t_enable;
        u_m.put(3'h1, 8'h20, r);
        u_m.ask(3'h1, v); chk("std enable", 8'h20, v);
        pulse(3'h4);
        chk("status byte", 8'h20, sbyte);
        u_m.clr();
        chk("status after clear", 8'h00, sbyte);
        u_m.put(3'h1, 8'h00, r);
        u_m.ask(3'h1, v); chk("enable zeroed", 8'h00, v);
        for (int s = 0; s < 8; s++) begin
            u_m.put(s[2:0], 8'h5a, r);
            chk("refused", {7'h00, !(s == 1 || s == 3 || s == 6)}, {7'h00, r});
        end
        foreach (v[i]) if (i inside {1, 3, 6}) begin
            u_m.ask(i[2:0], v); chk("enable readback", 8'h5a, v);
            u_m.put(i[2:0], 8'h00, r);
        end
        u_m.ask(3'h0, v); chk("std untouched", 8'h00, v);
        u_m.ask(3'h7, v); chk("unmapped", 8'h00, v);
    endtask : t_enable
    task t_op;
        int bits[6] = '{7, 6, 5, 4, 1, 0};
        foreach (bits[i]) begin
            cond = 8'h01 << bits[i];
            tk(4);
            u_m.ask(3'h4, v); chk("condition", cond, v);
            u_m.ask(3'h2, v); chk("op event", cond, v);
            cond = 8'h00;
            tk(4);
            u_m.ask(3'h4, v); chk("condition gone", 8'h00, v);
            u_m.ask(3'h2, v); chk("op event cleared", 8'h00, v);
        end
        disp = 1'b0;
        cond = 8'h01;
        tk(4);
        u_m.ask(3'h4, v); chk("alarm hidden", 8'h00, v);
        cond = 8'h00;
        disp = 1'b1;
        u_m.put(3'h3, 8'h10, r);
        cond = 8'h10;
        tk(4);
        chk("op summary", 8'h80, sbyte);
        u_m.ask(3'h2, v); chk("op event", 8'h10, v);
        chk("op summary cleared", 8'h00, sbyte);
        cond = 8'h00;
    endtask : t_op
    task t_freeze;
        en = 1'b0;
        pulse(3'h4);
        en = 1'b1;
        u_m.ask(3'h0, v); chk("frozen event", 8'h00, v);
    endtask : t_freeze
    initial begin
        forever #2.5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            summarize();
        end
    end
    initial begin
        repeat (6) @(negedge clk_i);
        rst_n_i = 1'b1;
        tk(3);
        t_power();
        t_std();
        t_enable();
        t_op();
        t_freeze();
        summarize();
    end
endmodule : status_event_register_sets_bench
bind ser_status_regs ser_status_regs_asserts u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .clk_en_i(clk_en_i), .rd_i(rd_i), .wr_i(wr_i), .sel_i(sel_i), .rdata_o(rdata_o),
    .rvalid_o(rvalid_o), .wr_refused_o(wr_refused_o),
    .std_event_summary_bit_o(std_event_summary_bit_o),
    .operation_summary_bit_o(operation_summary_bit_o), .status_byte_o(status_byte_o));
